// ===== hdl/sia_top.sv
// status and interrupt aggregator: master, loop detector and dma status registers
// assumes all inputs except RESET_N synchronous to CLK and a 16-bit word register port
//
// What this block does
// RULE1 - per-port loop flag on timeout or pattern
// RULE2 - timeout keeps flag set until detector reset
// RULE3 - host reads port control after loop flag
// RULE4 - loop status recording cannot be suppressed
// RULE5 - dma status flags queue accesses and errors
// RULE6 - dma status aggregates hdlc channel errors
// RULE7 - dma status recording cannot be suppressed
// RULE8 - bits 0/1 flag rx/tx alignment change
// RULE9 - host polls ports after alignment flag
// RULE10 - bit 2 flags bit tester state change
// RULE11 - bit 3 flags host system error
// RULE12 - bit 4 flags host parity error
// RULE13 - errors also reach config status field
// RULE14 - bit 14 flags ready missing nine clocks
// RULE15 - bit 15 flags local irq, host pin only
// RULE16 - reading status clears returned bits
// RULE17 - unmasked bit drives host and local irq; local irq only in configuration mode
// RULE18 - master mask same layout, resets zero
// RULE19 - masked bits still record events
// RULE20 - port alignment passes only when enabled
// RULE21 - loop mask one bit per port, resets zero
// RULE22 - irq pins low while any unmasked bit; local pin only in configuration mode
`include "sia_map.svh"
module sia_top import sia_pkg::*; #(
    parameter int NPORT = 16
) (
    input  wire logic             CLK,                  // system clock, 100 MHz
    input  wire logic             RESET_N,              // async reset, low active
    input  wire logic             CE,                   // clock enable, freezes state
    input  wire logic [15:0]      REG_ADDR,             // register word offset
    input  wire logic             REG_RD,               // read strobe
    input  wire logic             REG_WR,               // write strobe
    input  wire logic [15:0]      REG_WDATA,            // write data
    output logic      [15:0]      REG_RDATA,            // read data, registered
    output logic                  REG_RDATA_VALID,      // read data valid pulse
    input  wire logic [NPORT-1:0] RX_PORT_ALIGN_CHANGE, // rx alignment change pulses
    input  wire logic [NPORT-1:0] TX_PORT_ALIGN_CHANGE, // tx alignment change pulses
    input  wire logic [NPORT-1:0] RX_ALIGN_IRQ_ENABLE,  // per-port rx enables
    input  wire logic [NPORT-1:0] TX_ALIGN_IRQ_ENABLE,  // per-port tx enables
    input  wire logic             BIT_TESTER_CHANGE,    // bit tester state change pulse
    input  wire logic             HOST_SYSTEM_ERROR,    // address parity or system error pulse
    input  wire logic             HOST_PARITY_ERROR,    // data parity error pulse
    output logic                  CFG_SYSTEM_ERROR_SET, // config status system error pulse
    output logic                  CFG_PARITY_ERROR_SET, // config status parity error pulse
    input  wire logic             LOCAL_CONFIG_MODE,    // 1 = configuration mode, 0 = bridge
    input  wire logic             LOCAL_ACCESS_START,   // bridge access launched pulse
    input  wire logic             LOCAL_READY_PIN_N,    // local ready, low active
    input  wire logic             LOCAL_CLOCK_PIN,      // local clock, sampled
    input  wire logic             LOCAL_IRQ_PIN_N_I,    // local irq pin level
    output logic                  LOCAL_IRQ_PIN_N_O,    // local irq pin drive value
    output logic                  LOCAL_IRQ_PIN_OE_N,   // local irq drive enable, low drives
    output logic                  HOST_IRQ_PIN_N_O,     // host irq pin drive value
    output logic                  HOST_IRQ_PIN_OE_N,    // host irq drive enable, low drives
    input  wire logic [NPORT-1:0] LOOP_DETECT_EVENT,    // loop pattern found and verified
    input  wire logic [NPORT-1:0] LOOP_SEARCH_TIMEOUT,  // detector timeout level
    input  wire logic [15:0]      DMA_EVENT             // dma and hdlc event pulses
);
    logic [1:0]       rst_sync_q;
    logic             rst_n;
    logic             rd_take;
    logic             wr_take;
    sia_word_t        sm_set;
    sia_word_t        sm_status;
    sia_word_t        sm_mask;
    sia_word_t        sm_pend;
    sia_word_t        dma_status;
    sia_word_t        dma_mask;
    sia_word_t        dma_pend;
    logic [NPORT-1:0] loop_status;
    logic [NPORT-1:0] loop_mask;
    logic [NPORT-1:0] loop_pend;
    sia_lacc_state_t  la_state_q;
    sia_lacc_state_t  la_state_d;
    logic [3:0]       la_cnt_q;
    logic             local_clock_pin_q;
    logic             local_clock_pin_rise;
    logic             host_irq_q;
    logic             local_irq_q;

    function automatic logic hit(input sia_word_t addr, input sia_word_t off);
        hit = (addr == off);
    endfunction

    // the design relies on the released copy only, never on the raw pin
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    assign rd_take = REG_RD && CE;
    assign wr_take = REG_WR && CE;

    // master event sources; bridge-only bits are ignored in configuration mode
    always_comb begin
        sm_set = '0;
        sm_set[`SIA_BIT_RX_ALIGN]    = |(RX_PORT_ALIGN_CHANGE & RX_ALIGN_IRQ_ENABLE); // RULE8 RULE20
        sm_set[`SIA_BIT_TX_ALIGN]    = |(TX_PORT_ALIGN_CHANGE & TX_ALIGN_IRQ_ENABLE); // RULE8 RULE20
        sm_set[`SIA_BIT_BIT_TESTER]  = BIT_TESTER_CHANGE; // RULE10
        sm_set[`SIA_BIT_SYS_ERR]     = HOST_SYSTEM_ERROR; // RULE11
        sm_set[`SIA_BIT_PAR_ERR]     = HOST_PARITY_ERROR; // RULE12
        sm_set[`SIA_BIT_LOCAL_ABORT] = (la_state_q == SIA_LA_ABORT) && !LOCAL_CONFIG_MODE; // RULE14
        sm_set[`SIA_BIT_LOCAL_IRQ]   = !LOCAL_IRQ_PIN_N_I && !LOCAL_CONFIG_MODE; // RULE15
    end

    // unused master positions are fixed at zero by the write data mask
    sia_event_reg #(.W(16)) u_master (
        .clk       (CLK),
        .rst_n     (rst_n),
        .ce        (CE),
        .set_vec   (sm_set),
        .hold_vec  (16'h0000),
        .rd_clr    (rd_take && hit(REG_ADDR, `SIA_OFF_MASTER_STATUS)), // RULE16
        .mask_wr   (wr_take && hit(REG_ADDR, `SIA_OFF_MASTER_MASK)), // RULE18
        .mask_wdata(REG_WDATA & `SIA_MASTER_USED),
        .status_q  (sm_status),
        .mask_q    (sm_mask),
        .pend      (sm_pend)
    );

    // no enable term here: every dma event is recorded
    sia_event_reg #(.W(16)) u_dma (
        .clk       (CLK),
        .rst_n     (rst_n),
        .ce        (CE),
        .set_vec   (DMA_EVENT), // RULE5 RULE6 RULE7
        .hold_vec  (16'h0000),
        .rd_clr    (rd_take && hit(REG_ADDR, `SIA_OFF_DMA_STATUS)), // RULE16
        .mask_wr   (wr_take && hit(REG_ADDR, `SIA_OFF_DMA_MASK)),
        .mask_wdata(REG_WDATA),
        .status_q  (dma_status),
        .mask_q    (dma_mask),
        .pend      (dma_pend)
    );

    // a timed-out detector keeps its flag set until the host resets it
    sia_event_reg #(.W(NPORT)) u_loop (
        .clk       (CLK),
        .rst_n     (rst_n),
        .ce        (CE),
        .set_vec   (LOOP_DETECT_EVENT), // RULE1 RULE4
        .hold_vec  (LOOP_SEARCH_TIMEOUT), // RULE1 RULE2
        .rd_clr    (rd_take && hit(REG_ADDR, `SIA_OFF_LOOP_STATUS)), // RULE16
        .mask_wr   (wr_take && hit(REG_ADDR, `SIA_OFF_LOOP_MASK)), // RULE21
        .mask_wdata(REG_WDATA[NPORT-1:0]),
        .status_q  (loop_status),
        .mask_q    (loop_mask),
        .pend      (loop_pend)
    );

    // read data returns the value before the clear of the same edge
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            REG_RDATA <= 16'h0000;
        end else if (CE) begin
            if (rd_take) begin
                unique case (REG_ADDR)
                    `SIA_OFF_MASTER_STATUS: REG_RDATA <= sm_status;
                    `SIA_OFF_MASTER_MASK:   REG_RDATA <= sm_mask;
                    `SIA_OFF_DMA_STATUS:    REG_RDATA <= dma_status;
                    `SIA_OFF_DMA_MASK:      REG_RDATA <= dma_mask;
                    `SIA_OFF_LOOP_STATUS:   REG_RDATA <= 16'(loop_status);
                    `SIA_OFF_LOOP_MASK:     REG_RDATA <= 16'(loop_mask);
                    default:                REG_RDATA <= 16'h0000;
                endcase
            end
        end
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            REG_RDATA_VALID <= 1'b0;
        end else if (CE) begin
            REG_RDATA_VALID <= rd_take;
        end
    end

    // config space sees the same error events, one cycle later
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            CFG_SYSTEM_ERROR_SET <= 1'b0;
            CFG_PARITY_ERROR_SET <= 1'b0;
        end else if (CE) begin
            CFG_SYSTEM_ERROR_SET <= HOST_SYSTEM_ERROR; // RULE13
            CFG_PARITY_ERROR_SET <= HOST_PARITY_ERROR; // RULE13
        end
    end

    // local clock is a sampled input, so its edges are seen one clock late at most
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            local_clock_pin_q <= 1'b0;
        end else if (CE) begin
            local_clock_pin_q <= LOCAL_CLOCK_PIN;
        end
    end
    assign local_clock_pin_rise = LOCAL_CLOCK_PIN && !local_clock_pin_q;

    // ready watchdog for bridge accesses
    always_comb begin
        la_state_d = la_state_q;
        unique case (la_state_q)
            SIA_LA_IDLE: begin
                if (LOCAL_ACCESS_START && !LOCAL_CONFIG_MODE) begin
                    la_state_d = SIA_LA_WAIT;
                end
            end
            SIA_LA_WAIT: begin
                if (!LOCAL_READY_PIN_N) begin
                    la_state_d = SIA_LA_IDLE;
                end else if (local_clock_pin_rise && (la_cnt_q == `SIA_LOCAL_READY_PIN_LOCAL_CLOCK_PIN_LIMIT - 4'h1)) begin
                    la_state_d = SIA_LA_ABORT; // RULE14
                end
            end
            SIA_LA_ABORT: la_state_d = SIA_LA_IDLE;
            default:      la_state_d = SIA_LA_IDLE;
        endcase
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            la_state_q <= SIA_LA_IDLE;
        end else if (CE) begin
            la_state_q <= la_state_d;
        end
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            la_cnt_q <= 4'h0;
        end else if (CE) begin
            if (la_state_q != SIA_LA_WAIT) begin
                la_cnt_q <= 4'h0;
            end else if (local_clock_pin_rise) begin
                la_cnt_q <= la_cnt_q + 4'h1;
            end
        end
    end

    // masking only gates the pins; status keeps recording
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            host_irq_q  <= 1'b0;
            local_irq_q <= 1'b0;
        end else if (CE) begin
            host_irq_q  <= |{sm_pend, dma_pend, loop_pend}; // RULE17 RULE19 RULE22
            local_irq_q <= LOCAL_CONFIG_MODE && (|{sm_pend[14:0], dma_pend, loop_pend}); // RULE15 RULE17
        end
    end

    // both pins are open drain: drive low only while asserting
    assign HOST_IRQ_PIN_N_O   = 1'b0;
    assign HOST_IRQ_PIN_OE_N  = !host_irq_q; // RULE22
    assign LOCAL_IRQ_PIN_N_O  = 1'b0;
    assign LOCAL_IRQ_PIN_OE_N = !local_irq_q; // RULE22

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!rst_n);

    property p_set_wins;
        CE && HOST_SYSTEM_ERROR && rd_take && hit(REG_ADDR, `SIA_OFF_MASTER_STATUS)
            |=> sm_status[`SIA_BIT_SYS_ERR];
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("event lost in read cycle"); // RULE16

    property p_read_clears;
        CE && rd_take && hit(REG_ADDR, `SIA_OFF_DMA_STATUS) && (DMA_EVENT == 16'h0000)
            |=> (dma_status == 16'h0000) && REG_RDATA_VALID;
    endproperty
    a_read_clears: assert property (p_read_clears) else $error("dma status not cleared by read"); // RULE16

    property p_rdata_before_clear;
        CE && rd_take && hit(REG_ADDR, `SIA_OFF_MASTER_STATUS)
            |=> REG_RDATA == $past(sm_status);
    endproperty
    a_rdata_before_clear: assert property (p_rdata_before_clear) else $error("read data wrong"); // RULE16

    property p_align_gate;
        CE && (|(RX_PORT_ALIGN_CHANGE & RX_ALIGN_IRQ_ENABLE)) |=> sm_status[`SIA_BIT_RX_ALIGN];
    endproperty
    a_align_gate: assert property (p_align_gate) else $error("rx alignment change not recorded"); // RULE8

    property p_align_blocked;
        CE && !sm_status[`SIA_BIT_TX_ALIGN] && !(|(TX_PORT_ALIGN_CHANGE & TX_ALIGN_IRQ_ENABLE))
            |=> !sm_status[`SIA_BIT_TX_ALIGN];
    endproperty
    a_align_blocked: assert property (p_align_blocked) else $error("disabled alignment change set"); // RULE20

    // every port held in timeout must show its flag on the next cycle, even across a read
    property p_timeout_hold;
        CE && (|LOOP_SEARCH_TIMEOUT)
            |=> (loop_status & $past(LOOP_SEARCH_TIMEOUT)) == $past(LOOP_SEARCH_TIMEOUT);
    endproperty
    a_timeout_hold: assert property (p_timeout_hold) else $error("timeout flag dropped"); // RULE2

    property p_host_irq;
        CE && (|loop_pend) ##1 CE |-> !HOST_IRQ_PIN_OE_N;
    endproperty
    a_host_irq: assert property (p_host_irq) else $error("host irq missing"); // RULE17

    property p_irq_release;
        CE && !(|{sm_pend, dma_pend, loop_pend}) |=> HOST_IRQ_PIN_OE_N && LOCAL_IRQ_PIN_OE_N;
    endproperty
    a_irq_release: assert property (p_irq_release) else $error("irq held without cause"); // RULE22

    property p_local_irq_bridge;
        CE && !LOCAL_CONFIG_MODE |=> LOCAL_IRQ_PIN_OE_N;
    endproperty
    a_local_irq_bridge: assert property (p_local_irq_bridge) else $error("local irq in bridge mode"); // RULE17

    property p_masked_records;
        CE && BIT_TESTER_CHANGE && !sm_mask[`SIA_BIT_BIT_TESTER]
            |=> sm_status[`SIA_BIT_BIT_TESTER] && !sm_pend[`SIA_BIT_BIT_TESTER];
    endproperty
    a_masked_records: assert property (p_masked_records) else $error("masked event not recorded"); // RULE19

    property p_abort_count;
        la_state_q == SIA_LA_ABORT && $past(la_state_q) == SIA_LA_WAIT
            |-> $past(la_cnt_q) == `SIA_LOCAL_READY_PIN_LOCAL_CLOCK_PIN_LIMIT - 4'h1;
    endproperty
    a_abort_count: assert property (p_abort_count) else $error("abort not after nine edges"); // RULE14

    property p_abort_flag;
        CE && la_state_q == SIA_LA_ABORT && !LOCAL_CONFIG_MODE |=> sm_status[`SIA_BIT_LOCAL_ABORT];
    endproperty
    a_abort_flag: assert property (p_abort_flag) else $error("abort flag not set"); // RULE14

    property p_cfg_mirror;
        CE && HOST_PARITY_ERROR |=> CFG_PARITY_ERROR_SET && sm_status[`SIA_BIT_PAR_ERR];
    endproperty
    a_cfg_mirror: assert property (p_cfg_mirror) else $error("parity error not mirrored"); // RULE13

    c_abort:     cover property (la_state_q == SIA_LA_ABORT);
    c_host_irq:  cover property (!HOST_IRQ_PIN_OE_N ##[1:20] HOST_IRQ_PIN_OE_N);
    c_local_irq: cover property (!LOCAL_IRQ_PIN_OE_N);
    c_set_clear: cover property (rd_take && (|DMA_EVENT) && hit(REG_ADDR, `SIA_OFF_DMA_STATUS));
endmodule

// ===== include/sia_map.svh
// register map, field positions, reset values and timing counts of the status aggregator
// assumes a 16-bit word register port with word offsets as printed
`ifndef SIA_MAP_SVH
`define SIA_MAP_SVH
`define SIA_OFF_MASTER_STATUS  16'h0020
`define SIA_OFF_MASTER_MASK    16'h0024
`define SIA_OFF_DMA_STATUS     16'h0028
`define SIA_OFF_DMA_MASK       16'h002c
`define SIA_OFF_LOOP_STATUS    16'h0030
`define SIA_OFF_LOOP_MASK      16'h0034
`define SIA_BIT_RX_ALIGN       0
`define SIA_BIT_TX_ALIGN       1
`define SIA_BIT_BIT_TESTER     2
`define SIA_BIT_SYS_ERR        3
`define SIA_BIT_PAR_ERR        4
`define SIA_BIT_LOCAL_ABORT    14
`define SIA_BIT_LOCAL_IRQ      15
`define SIA_MASTER_USED        16'hc01f
`define SIA_RST_STATUS         16'h0000
`define SIA_RST_MASK           16'h0000
`define SIA_LOCAL_READY_PIN_LOCAL_CLOCK_PIN_LIMIT    4'h9
`endif

// ===== include/sia_pkg.sv
// types shared by the status aggregator modules
// assumes sia_map.svh holds every number
package sia_pkg;
    typedef logic [15:0] sia_word_t;
    typedef enum logic [1:0] {
        SIA_LA_IDLE  = 2'b00,
        SIA_LA_WAIT  = 2'b01,
        SIA_LA_ABORT = 2'b11
    } sia_lacc_state_t;
endpackage

// ===== hdl/sia_event_reg.sv
// one clear-on-read event status register with its interrupt mask
// assumes synchronous reset copy, event pulses and hold levels in the clk domain
`include "sia_map.svh"
module sia_event_reg import sia_pkg::*; #(
    parameter int W = 16
) (
    input  wire logic         clk,       // system clock
    input  wire logic         rst_n,     // synchronised reset, low active
    input  wire logic         ce,        // clock enable
    input  wire logic [W-1:0] set_vec,   // one-cycle event pulses
    input  wire logic [W-1:0] hold_vec,  // levels that keep a bit set
    input  wire logic         rd_clr,    // status read taken this cycle
    input  wire logic         mask_wr,   // mask write taken this cycle
    input  wire logic [W-1:0] mask_wdata,// new mask value
    output logic      [W-1:0] status_q,  // sticky status
    output logic      [W-1:0] mask_q,    // mask, 1 = unmasked
    output logic      [W-1:0] pend       // status gated by mask
);
    logic [W-1:0] status_d;

    // a set in the read cycle survives the clear, so no event is lost
    always_comb begin
        status_d = status_q;
        if (rd_clr) begin
            status_d = '0;
        end
        status_d = status_d | set_vec | hold_vec;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            status_q <= W'(`SIA_RST_STATUS);
        end else if (ce) begin
            status_q <= status_d;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mask_q <= W'(`SIA_RST_MASK);
        end else if (ce && mask_wr) begin
            mask_q <= mask_wdata;
        end
    end

    assign pend = status_q & mask_q;
endmodule

// ===== testbench/sia_local_peer.sv
// local bus peripheral beside the aggregator: local clock, ready and interrupt pins
// assumes the bench launches one access at a time with go; clock and ready pins change by nba on rising edges
module sia_local_peer (
    input  wire logic       clk,         // system clock
    input  wire logic       go,          // launch one local access
    input  wire logic [3:0] ready_after, // ready answers at this rise count, 15 = never
    input  wire logic       irq_req,     // peripheral wants service
    output logic            local_clock_pin,        // local clock, still outside an access
    output logic            local_ready_pin_n,      // local ready, pulled up when released
    output logic            local_irq_pin_n       // local interrupt, pulled up when released
);
    timeunit 1ns;
    timeprecision 1ps;
    int   ph;
    int   rises;
    logic busy;

    initial begin
        local_clock_pin   = 1'b0;
        local_ready_pin_n = 1'b1;
        busy   = 1'b0;
        ph     = 0;
        rises  = 0;
    end

    // go is sampled on the rising edge, so the bench's falling-edge drive never races it
    always @(posedge clk) begin
        if (go && !busy) begin
            busy  <= 1'b1;
            ph    <= 0;
            rises <= 0;
        end else if (busy && rises == 12) begin
            // park the local clock low and release ready between accesses
            busy   <= 1'b0;
            local_clock_pin   <= 1'b0;
            local_ready_pin_n <= 1'b1;
        end else if (busy) begin
            ph <= ph + 1;
            if (ph % 2 == 1) begin
                local_clock_pin <= ~local_clock_pin;
                if (!local_clock_pin) begin
                    rises <= rises + 1;
                end
            end
            // ready is only a pulse so the line returns to its pull-up level
            local_ready_pin_n <= !(rises == int'(ready_after));
        end
    end

    assign local_irq_pin_n = irq_req ? 1'b0 : 1'b1;
endmodule

// ===== testbench/sia_bench.sv
// self-checking bench for the status aggregator, registers reached by word strobes
// assumes the design answers reads one cycle after the taking edge
`include "sia_map.svh"
module sia_bench import sia_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 0, rst_n = 0, rd = 0, wr = 0, bt = 0, se = 0, pe = 0, cfg = 1, start = 0, irq = 0, ce = 1;
    logic [15:0] addr = 0, wdata = 0, rdata, dma = 0;
    logic [15:0] rxa = 0, txa = 0, rxe = 0, txe = 0, ldet = 0, lto = 0;
    logic        valid, cfg_se, cfg_pe, loc_oe_n, host_oe_n, local_clock_pin, local_ready_pin_n, local_irq_pin_n, host_n_o, loc_n_o;
    logic [3:0]  rdy_after = 4'hf;
    int          bad_count = 0, tests_run = 0;
    sia_word_t   w;

    always #5 clk = ~clk;

    sia_local_peer i_sia_local_peer (.clk(clk), .go(start), .ready_after(rdy_after), .irq_req(irq),
        .local_clock_pin(local_clock_pin), .local_ready_pin_n(local_ready_pin_n), .local_irq_pin_n(local_irq_pin_n));

    sia_top #(.NPORT(16)) i_sia_top (.CLK(clk), .RESET_N(rst_n), .CE(ce), .REG_ADDR(addr),
        .REG_RD(rd), .REG_WR(wr), .REG_WDATA(wdata), .REG_RDATA(rdata), .REG_RDATA_VALID(valid),
        .RX_PORT_ALIGN_CHANGE(rxa), .TX_PORT_ALIGN_CHANGE(txa), .RX_ALIGN_IRQ_ENABLE(rxe),
        .TX_ALIGN_IRQ_ENABLE(txe), .BIT_TESTER_CHANGE(bt), .HOST_SYSTEM_ERROR(se),
        .HOST_PARITY_ERROR(pe), .CFG_SYSTEM_ERROR_SET(cfg_se), .CFG_PARITY_ERROR_SET(cfg_pe),
        .LOCAL_CONFIG_MODE(cfg), .LOCAL_ACCESS_START(start), .LOCAL_READY_PIN_N(local_ready_pin_n),
        .LOCAL_CLOCK_PIN(local_clock_pin), .LOCAL_IRQ_PIN_N_I(local_irq_pin_n), .LOCAL_IRQ_PIN_N_O(loc_n_o),
        .LOCAL_IRQ_PIN_OE_N(loc_oe_n), .HOST_IRQ_PIN_N_O(host_n_o), .HOST_IRQ_PIN_OE_N(host_oe_n),
        .LOOP_DETECT_EVENT(ldet), .LOOP_SEARCH_TIMEOUT(lto), .DMA_EVENT(dma));

    task automatic complete_run();
        if (bad_count == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input sia_word_t got, input sia_word_t exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        chk({15'h0000, got}, {15'h0000, exp});
    endtask

    task automatic reg_wr(input logic [15:0] a, input sia_word_t d);
        @(negedge clk);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
    endtask

    task automatic reg_rd(input logic [15:0] a, input sia_word_t exp);
        int n;
        n = 0;
        @(negedge clk);
        addr = a;
        rd = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        while (valid !== 1'b1 && n < 4) begin
            @(negedge clk);
            n++;
        end
        if (n == 4) begin
            bad_count++;
            $display("CHECK FAILED at %0t: no read answer", $time);
            complete_run();
        end else begin
            chk(rdata, exp);
        end
    endtask

    task automatic t_refuse();
        chk1(host_oe_n, 1'b1);
        chk1(host_n_o, 1'b0);
        chk1(loc_n_o, 1'b0);
        reg_rd(`SIA_OFF_MASTER_MASK, 16'h0000);
        reg_rd(`SIA_OFF_LOOP_MASK, 16'h0000);
        reg_wr(`SIA_OFF_MASTER_STATUS, 16'hffff);
        reg_rd(`SIA_OFF_MASTER_STATUS, 16'h0000);
        reg_wr(`SIA_OFF_MASTER_MASK, 16'hffff);
        reg_rd(`SIA_OFF_MASTER_MASK, `SIA_MASTER_USED);
        reg_rd(16'h003c, 16'h0000);
        reg_wr(`SIA_OFF_MASTER_MASK, 16'h001f);
    endtask

    task automatic t_master();
        @(negedge clk);
        {bt, se, pe} = 3'b111;
        @(negedge clk);
        {bt, se, pe} = 3'b000;
        chk1(cfg_se, 1'b1);
        chk1(cfg_pe, 1'b1);
        @(negedge clk);
        chk1(host_oe_n, 1'b0);
        chk1(loc_oe_n, 1'b0);
        reg_rd(`SIA_OFF_MASTER_STATUS, 16'h001c);
        reg_rd(`SIA_OFF_MASTER_STATUS, 16'h0000);
        chk1(host_oe_n, 1'b1);
    endtask

    // frozen clock enable drops the tester pulse; an error held through a read survives the clear
    task automatic t_freeze();
        @(negedge clk);
        ce = 1'b0;
        bt = 1'b1;
        @(negedge clk);
        {ce, bt, se} = 3'b101;
        reg_rd(`SIA_OFF_MASTER_STATUS, 16'h0008);
        se = 1'b0;
        reg_rd(`SIA_OFF_MASTER_STATUS, 16'h0008);
        reg_rd(`SIA_OFF_MASTER_STATUS, 16'h0000);
    endtask

    task automatic t_align();
        @(negedge clk);
        txe = 16'h0020;
        rxa = 16'h0008;
        txa = 16'h0020;
        @(negedge clk);
        {rxa, txa} = 32'h0000_0000;
        reg_rd(`SIA_OFF_MASTER_STATUS, 16'h0002);
        rxe = 16'h0008;
        @(negedge clk);
        rxa = 16'h0008;
        @(negedge clk);
        rxa = 16'h0000;
        reg_rd(`SIA_OFF_MASTER_STATUS, 16'h0001);
    endtask

    task automatic t_dma();
        @(negedge clk);
        dma = 16'h8421;
        @(negedge clk);
        dma = 16'h0000;
        repeat (2) @(negedge clk);
        chk1(host_oe_n, 1'b1);
        reg_rd(`SIA_OFF_DMA_STATUS, 16'h8421);
        reg_wr(`SIA_OFF_DMA_MASK, 16'h8421);
        reg_rd(`SIA_OFF_DMA_MASK, 16'h8421);
        dma = 16'h0001;
        @(negedge clk);
        dma = 16'h0000;
        @(negedge clk);
        chk1(host_oe_n, 1'b0);
        reg_rd(`SIA_OFF_DMA_STATUS, 16'h0001);
    endtask

    task automatic t_loop();
        @(negedge clk);
        lto = 16'h0004;
        ldet = 16'h0080;
        @(negedge clk);
        ldet = 16'h0000;
        reg_rd(`SIA_OFF_LOOP_STATUS, 16'h0084);
        reg_rd(`SIA_OFF_LOOP_STATUS, 16'h0004);
        lto = 16'h0000;
        repeat (3) @(negedge clk);
        reg_rd(`SIA_OFF_LOOP_STATUS, 16'h0004);
        reg_rd(`SIA_OFF_LOOP_STATUS, 16'h0000);
        reg_wr(`SIA_OFF_LOOP_MASK, 16'h0080);
        reg_rd(`SIA_OFF_LOOP_MASK, 16'h0080);
        ldet = 16'h0080;
        @(negedge clk);
        ldet = 16'h0000;
        @(negedge clk);
        chk1(loc_oe_n, 1'b0);
        reg_rd(`SIA_OFF_LOOP_STATUS, 16'h0080);
    endtask

    task automatic local_access(input logic [3:0] ra);
        @(negedge clk);
        rdy_after = ra;
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
        repeat (60) @(negedge clk);
    endtask

    task automatic t_local();
        cfg = 1'b0;
        reg_wr(`SIA_OFF_MASTER_MASK, 16'h8000);
        local_access(4'h2);
        reg_rd(`SIA_OFF_MASTER_STATUS, 16'h0000);
        local_access(4'hf);
        reg_rd(`SIA_OFF_MASTER_STATUS, 16'h4000);
        @(negedge clk);
        irq = 1'b1;
        @(negedge clk);
        irq = 1'b0;
        @(negedge clk);
        chk1(host_oe_n, 1'b0);
        chk1(loc_oe_n, 1'b1);
        reg_rd(`SIA_OFF_MASTER_STATUS, 16'h8000);
    endtask

    initial begin
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        t_refuse();
        t_master();
        t_freeze();
        t_align();
        t_dma();
        t_loop();
        t_local();
        complete_run();
    end

    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        complete_run();
    end
endmodule
